// ---- core/sgp_pkg.sv ----
/*
  Shared constants and carrier types for the seven-port shared GPIO block.
  Assumes a 32-bit APB register bus and one synchronous clock domain.
*/
package sgp_pkg;
  // ==========================================================
  // Port geometry
  localparam int NUM_PORTS = 7;
  localparam int PORT_W = 8;
  localparam int TOTAL_PINS = 38;
  localparam int G_IDX = 6;
  // Index 0 is port A, index 6 is port G
  localparam logic [6:0][7:0] PIN_MASK =
    {8'h7F, 8'h73, 8'hFF, 8'h0F, 8'h3F, 8'h0F, 8'h87};
  localparam logic [6:0][7:0] SHARE_MASK =
    {8'h00, 8'h33, 8'hFF, 8'h0F, 8'h2F, 8'h0F, 8'h00};
  localparam logic [6:0][7:0] ANALOG_MASK =
    {8'h00, 8'h00, 8'h00, 8'h0F, 8'h00, 8'h0F, 8'h00};
  localparam logic [7:0] KBD_MASK_G = 8'h7F;
  localparam logic [7:0] OSC_MASK_G = 8'h60;

  // ==========================================================
  // Register map, byte addresses
  localparam int ADDR_W = 12;
  localparam logic [11:0] ZP_BASE = 12'h000;
  localparam logic [11:0] HP_BASE = 12'h100;
  localparam int ZP_STRIDE_LSB = 3;
  localparam int HP_STRIDE_LSB = 4;
  localparam logic [1:0] HP_PULL_SEL = 2'h0;
  localparam logic [1:0] HP_SLEW_SEL = 2'h1;
  localparam logic [1:0] HP_DRIVE_SEL = 2'h2;

  // ==========================================================
  // Reset values
  localparam logic [6:0][7:0] DATA_RST = '0;
  localparam logic [6:0][7:0] DIR_RST = '0;
  localparam logic [6:0][7:0] PULL_RST = '0;
  localparam logic [6:0][7:0] SLEW_RST = PIN_MASK;
  localparam logic [6:0][7:0] DRIVE_RST = '0;

  // ==========================================================
  // Types
  typedef enum logic [5:0] {
    RK_NONE  = 6'b00_0001,
    RK_DATA  = 6'b00_0010,
    RK_DIR   = 6'b00_0100,
    RK_PULL  = 6'b00_1000,
    RK_SLEW  = 6'b01_0000,
    RK_DRIVE = 6'b10_0000
  } sgp_reg_kind_type;

  typedef struct packed {
    logic [7:0] en;
    logic [7:0] oe;
    logic [7:0] dout;
    logic [7:0] analog;
  } sgp_share_type;

  typedef struct packed {
    logic [7:0] out;
    logic [7:0] oe;
    logic [7:0] pull_on;
    logic [7:0] slew;
    logic [7:0] drive;
    logic [7:0] analog;
  } sgp_pad_type;

  typedef struct packed {
    logic [6:0][7:0] data;
    logic [6:0][7:0] dir;
    logic [6:0][7:0] pull;
    logic [6:0][7:0] slew;
    logic [6:0][7:0] drive;
  } sgp_bank_type;
endpackage : sgp_pkg

// ---- core/sgp_pin_cell.sv ----
/*
  One pin's ownership and pad control mux.
  Assumes the owning peripherals present enable, direction and level.
*/
module sgp_pin_cell (
  // Register bits
  input wire logic impl,
  input wire logic dat,
  input wire logic ddr,
  input wire logic pe,
  input wire logic se,
  input wire logic ds,
  // Sharing
  input wire logic p_en,
  input wire logic p_oe,
  input wire logic p_out,
  input wire logic analog,
  input wire logic kbd,
  input wire logic osc,
  input wire logic pin,
  // Results
  output logic out,
  output logic oe,
  output logic pull_on,
  output logic slew,
  output logic drive,
  output logic an_sel,
  output logic rd
);
  logic periph;
  logic off;

  always_comb begin
    // Analog wins over any digital claimant
    periph = p_en && !analog;
    off = !impl || analog || osc;
    if (off) begin
      oe = 1'b0;
    end else if (kbd) begin
      oe = 1'b0;
    end else if (periph) begin
      oe = p_oe;
    end else begin
      oe = ddr;
    end
    out = (periph && p_oe) ? p_out : dat;
    out = out && !off;
    pull_on = pe && !oe && !off;
    slew = se && impl && !osc;
    drive = ds && impl && !osc;
    an_sel = analog && impl;
    // Direction bit picks the read source even under peripheral or keyboard override
    rd = off ? 1'b0 : (ddr ? dat : pin);
  end
endmodule // sgp_pin_cell

// ---- core/sgp_addr_decode.sv ----
/*
  APB address decoder for the port register map.
  Assumes byte addresses with one aligned word per register.
*/
module sgp_addr_decode (
  // Address in
  input wire logic [11:0] addr,
  // Decoded target
  output sgp_pkg::sgp_reg_kind_type kind,
  output logic [2:0] port
);
  logic [11:0] off;

  always_comb begin
    kind = sgp_pkg::RK_NONE;
    port = 3'h0;
    off = addr - sgp_pkg::HP_BASE;
    if (addr[1:0] != 2'h0) begin
      kind = sgp_pkg::RK_NONE;
    end else if (addr < sgp_pkg::HP_BASE) begin
      // Zero-page data and direction pairs
      port = addr[5:3];
      if (addr[11:6] == 6'h00 && addr[5:3] != 3'h7) begin
        kind = addr[2] ? sgp_pkg::RK_DIR : sgp_pkg::RK_DATA;
      end
    end else begin
      // High-page pin control triples
      port = off[6:4];
      if (off[11:7] == 5'h00 && off[6:4] != 3'h7) begin
        unique case (off[3:2])
          sgp_pkg::HP_PULL_SEL: kind = sgp_pkg::RK_PULL;
          sgp_pkg::HP_SLEW_SEL: kind = sgp_pkg::RK_SLEW;
          sgp_pkg::HP_DRIVE_SEL: kind = sgp_pkg::RK_DRIVE;
          default: kind = sgp_pkg::RK_NONE;
        endcase
      end
    end
  end
endmodule // sgp_addr_decode

// ---- core/sgp_top.sv ----
/*
  Seven shared general-purpose ports with APB register access.
  Assumes peripherals present enable, direction and level per pin, and
  that pad cells resolve the level from the registered enables.
*/
module sgp_top (
  // Clock and reset
  input wire logic REF_CLK,
  input wire logic RST,
  // APB slave
  input wire logic PSEL,
  input wire logic PENABLE,
  input wire logic PWRITE,
  input wire logic [11:0] PADDR,
  input wire logic [31:0] PWDATA,
  input wire logic [3:0] PSTRB,
  output logic [31:0] PRDATA,
  output logic PREADY,
  output logic PSLVERR,
  // Peripheral sharing
  input wire sgp_pkg::sgp_share_type [6:0] SHARE,
  input wire logic [7:0] KBD_EN,
  input wire logic OSC_EN,
  // Pads
  input wire logic [6:0][7:0] PIN_IN,
  output sgp_pkg::sgp_pad_type [6:0] PAD_CTRL
);
  // ==========================================================
  // State
  typedef struct packed {
    sgp_pkg::sgp_bank_type bank;
    sgp_pkg::sgp_pad_type [6:0] pad;
    logic [7:0] rdata;
  } sgp_state_type;

  localparam sgp_state_type STATE_RST = '{
    bank: '{
      data: sgp_pkg::DATA_RST,
      dir: sgp_pkg::DIR_RST,
      pull: sgp_pkg::PULL_RST,
      slew: sgp_pkg::SLEW_RST,
      drive: sgp_pkg::DRIVE_RST
    },
    pad: '0,
    rdata: 8'h00
  };

  sgp_state_type st;
  sgp_state_type next_st;
  sgp_pkg::sgp_reg_kind_type kind;
  logic [2:0] port;
  logic setup;
  logic wr;
  wire logic [6:0][7:0] c_out;
  wire logic [6:0][7:0] c_oe;
  wire logic [6:0][7:0] c_pu;
  wire logic [6:0][7:0] c_sl;
  wire logic [6:0][7:0] c_dr;
  wire logic [6:0][7:0] c_an;
  wire logic [6:0][7:0] c_rd;
  logic [6:0][7:0] sh_en;
  logic [6:0][7:0] sh_an;
  logic [6:0][7:0] kbd;
  logic [6:0][7:0] osc;

  // ==========================================================
  // Address decode
  sgp_addr_decode u_dec (
    .addr(PADDR),
    .kind(kind),
    .port(port)
  );

  // ==========================================================
  // Ownership masks
  always_comb begin
    for (int p = 0; p < sgp_pkg::NUM_PORTS; p++) begin
      // Port A and G have no generic sharing; masks keep them plain
      sh_en[p] = SHARE[p].en & sgp_pkg::SHARE_MASK[p];
      sh_an[p] = SHARE[p].analog & sgp_pkg::ANALOG_MASK[p];
      kbd[p] = 8'h00;
      osc[p] = 8'h00;
    end
    kbd[sgp_pkg::G_IDX] = KBD_EN & sgp_pkg::KBD_MASK_G;
    osc[sgp_pkg::G_IDX] = OSC_EN ? sgp_pkg::OSC_MASK_G : 8'h00;
  end

  // ==========================================================
  // Pin cells
  for (genvar p = 0; p < sgp_pkg::NUM_PORTS; p++) begin : g_port
    for (genvar b = 0; b < sgp_pkg::PORT_W; b++) begin : g_bit
      sgp_pin_cell u_cell (
        .impl(sgp_pkg::PIN_MASK[p][b]),
        .dat(st.bank.data[p][b]),
        .ddr(st.bank.dir[p][b]),
        .pe(st.bank.pull[p][b]),
        .se(st.bank.slew[p][b]),
        .ds(st.bank.drive[p][b]),
        .p_en(sh_en[p][b]),
        .p_oe(SHARE[p].oe[b]),
        .p_out(SHARE[p].dout[b]),
        .analog(sh_an[p][b]),
        .kbd(kbd[p][b]),
        .osc(osc[p][b]),
        .pin(PIN_IN[p][b]),
        .out(c_out[p][b]),
        .oe(c_oe[p][b]),
        .pull_on(c_pu[p][b]),
        .slew(c_sl[p][b]),
        .drive(c_dr[p][b]),
        .an_sel(c_an[p][b]),
        .rd(c_rd[p][b])
      );
    end
  end

  // ==========================================================
  // Next state
  assign setup = PSEL && !PENABLE;
  assign wr = PSEL && PENABLE && PWRITE && PSTRB[0];

  always_comb begin
    next_st = st;
    // Read data is captured in the setup phase so access has no wait
    if (setup && !PWRITE) begin
      unique case (kind)
        sgp_pkg::RK_DATA: next_st.rdata = c_rd[port];
        sgp_pkg::RK_DIR: next_st.rdata = st.bank.dir[port];
        sgp_pkg::RK_PULL: next_st.rdata = st.bank.pull[port];
        sgp_pkg::RK_SLEW: next_st.rdata = st.bank.slew[port];
        sgp_pkg::RK_DRIVE: next_st.rdata = st.bank.drive[port];
        sgp_pkg::RK_NONE: next_st.rdata = 8'h00;
      endcase
    end
    if (wr) begin
      // Reserved positions never take a one
      unique case (kind)
        sgp_pkg::RK_DATA: next_st.bank.data[port] =
          PWDATA[7:0] & sgp_pkg::PIN_MASK[port];
        sgp_pkg::RK_DIR: next_st.bank.dir[port] =
          PWDATA[7:0] & sgp_pkg::PIN_MASK[port];
        sgp_pkg::RK_PULL: next_st.bank.pull[port] =
          PWDATA[7:0] & sgp_pkg::PIN_MASK[port];
        sgp_pkg::RK_SLEW: next_st.bank.slew[port] =
          PWDATA[7:0] & sgp_pkg::PIN_MASK[port];
        sgp_pkg::RK_DRIVE: next_st.bank.drive[port] =
          PWDATA[7:0] & sgp_pkg::PIN_MASK[port];
        sgp_pkg::RK_NONE: next_st.bank = st.bank;
      endcase
    end
    for (int p = 0; p < sgp_pkg::NUM_PORTS; p++) begin
      next_st.pad[p].out = c_out[p];
      next_st.pad[p].oe = c_oe[p];
      next_st.pad[p].pull_on = c_pu[p];
      next_st.pad[p].slew = c_sl[p];
      next_st.pad[p].drive = c_dr[p];
      next_st.pad[p].analog = c_an[p];
    end
  end

  always_ff @(posedge REF_CLK or posedge RST) begin
    if (RST) begin
      st <= STATE_RST;
    end else begin
      st <= next_st;
    end
  end

  // ==========================================================
  // Outputs
  assign PREADY = 1'b1;
  assign PSLVERR = PSEL && PENABLE && (kind == sgp_pkg::RK_NONE);
  assign PRDATA = {24'h00_0000, st.rdata};
  assign PAD_CTRL = st.pad;

  // ==========================================================
  // Checks
  default clocking cb @(posedge REF_CLK); endclocking
  default disable iff (RST);

  logic [6:0][7:0] q_oe;
  logic [6:0][7:0] q_pu;
  logic [6:0][7:0] q_an;
  logic [6:0][7:0] exp_rd;
  always_comb begin
    for (int p = 0; p < sgp_pkg::NUM_PORTS; p++) begin
      q_oe[p] = st.pad[p].oe;
      q_pu[p] = st.pad[p].pull_on;
      q_an[p] = st.pad[p].analog;
      exp_rd[p] = ((st.bank.dir[p] & st.bank.data[p])
        | (~st.bank.dir[p] & PIN_IN[p])) & ~sh_an[p]
        & sgp_pkg::PIN_MASK[p] & ~osc[p];
    end
  end

  sequence s_rd_setup;
    setup && !PWRITE && kind == sgp_pkg::RK_DATA;
  endsequence

  property p_rst_dir;
    $past(RST) |-> st.bank.dir == '0 && q_oe == '0;
  endproperty
  a_rst_dir: assert property (p_rst_dir)
    else $error("direction not clear after reset");

  property p_rst_ctrl;
    $past(RST) |-> st.bank.slew == sgp_pkg::PIN_MASK
      && st.bank.pull == '0 && st.bank.drive == '0;
  endproperty
  a_rst_ctrl: assert property (p_rst_ctrl)
    else $error("pin control reset value wrong");

  property p_read_data;
    logic [7:0] e;
    (s_rd_setup, e = exp_rd[port]) ##1 (PSEL && PENABLE)
      |-> PRDATA == {24'h00_0000, e};
  endproperty
  a_read_data: assert property (p_read_data)
    else $error("data read source wrong");

  property p_analog_read;
    logic [7:0] a;
    (s_rd_setup, a = sh_an[port]) |=> (PRDATA[7:0] & a) == 8'h00;
  endproperty
  a_analog_read: assert property (p_analog_read)
    else $error("analog bit read not zero");

  property p_analog_pad;
    ##1 ((q_oe | q_pu) & $past(sh_an)) == '0 && q_an == $past(sh_an);
  endproperty
  a_analog_pad: assert property (p_analog_pad)
    else $error("analog pin still digital");

  property p_pull_off;
    (q_pu & q_oe) == '0;
  endproperty
  a_pull_off: assert property (p_pull_off)
    else $error("pullup on an output");

  property p_osc;
    $past(OSC_EN) |-> ((st.pad[6].oe | st.pad[6].pull_on
      | st.pad[6].slew | st.pad[6].drive) & sgp_pkg::OSC_MASK_G) == 8'h00;
  endproperty
  a_osc: assert property (p_osc)
    else $error("oscillator pin under port control");

  property p_kbd;
    ##1 (st.pad[6].oe & $past(kbd[6])) == 8'h00;
  endproperty
  a_kbd: assert property (p_kbd)
    else $error("keyboard pin driving");

  property p_share_dir;
    ##1 (q_oe & $past(sh_en & ~sh_an)) == $past(
      sh_en & ~sh_an & {SHARE[6].oe, SHARE[5].oe, SHARE[4].oe,
      SHARE[3].oe, SHARE[2].oe, SHARE[1].oe, SHARE[0].oe});
  endproperty
  a_share_dir: assert property (p_share_dir)
    else $error("peripheral did not own direction");

  property p_port_a;
    ##1 st.pad[0].oe == $past(st.bank.dir[0]);
  endproperty
  a_port_a: assert property (p_port_a)
    else $error("port A direction not from register");
endmodule // sgp_top

// ---- verification/sgp_board.sv ----
/*
  Board model for the seven shared ports: pads driven by the block win,
  else the board drives chosen lines, else a pullup or a floating wobble.
  Assumes PAD_CTRL from the block and drive masks from the testbench.
*/
module sgp_board (
  // Clock
  input wire logic clk,
  // Block side
  input wire sgp_pkg::sgp_pad_type [6:0] pad,
  // Board drive
  input wire logic [6:0][7:0] drv,
  input wire logic [6:0][7:0] val,
  // Pad levels
  output logic [6:0][7:0] pin
);
  // ==========================================================
  // Floating lines
  // A released line must not keep a stale level, so it toggles
  logic [6:0][7:0] wobble = '0;
  always @(posedge clk) begin
    wobble <= ~wobble;
  end

  // ==========================================================
  // Wire resolution
  always_comb begin
    for (int p = 0; p < 7; p++) begin
      pin[p] = (pad[p].oe & pad[p].out) | (~pad[p].oe & drv[p] & val[p]) |
               (~pad[p].oe & ~drv[p] & (pad[p].pull_on | wobble[p]));
    end
  end
endmodule // sgp_board

// ---- verification/sgp_top_test.sv ----
/*
  Self-checking testbench for the shared port block.
  Assumes an APB master at the register side and the board model on pads.
*/
module sgp_top_test;
  timeunit 1ns;
  timeprecision 1ps;
  // ==========================================================
  // Signals
  logic REF_CLK = 0, RST = 1, PSEL = 0, PENABLE = 0, PWRITE = 0;
  logic [11:0] PADDR = '0;
  logic [31:0] PWDATA = '0;
  logic [3:0] PSTRB = 4'hF;
  wire logic [31:0] PRDATA;
  wire logic PREADY, PSLVERR;
  sgp_pkg::sgp_share_type [6:0] SHARE = '0;
  logic [7:0] KBD_EN = '0;
  logic OSC_EN = 0;
  wire logic [6:0][7:0] PIN_IN;
  wire sgp_pkg::sgp_pad_type [6:0] PAD_CTRL;
  logic [6:0][7:0] ext_drv = '0, ext_val = '0;
  logic [6:0][7:0] s_data = '0, s_dir = '0, s_pull = '0, s_slew, s_drv = '0;
  logic [31:0] seed = 32'hBD19_37E3, q;
  logic err;
  int error_cnt = 0, n_compared = 0, cycles = 0, total = 0;

  sgp_top u_dut (.REF_CLK(REF_CLK), .RST(RST), .PSEL(PSEL),
    .PENABLE(PENABLE), .PWRITE(PWRITE), .PADDR(PADDR), .PWDATA(PWDATA),
    .PSTRB(PSTRB), .PRDATA(PRDATA), .PREADY(PREADY), .PSLVERR(PSLVERR),
    .SHARE(SHARE), .KBD_EN(KBD_EN), .OSC_EN(OSC_EN), .PIN_IN(PIN_IN),
    .PAD_CTRL(PAD_CTRL));
  sgp_board u_board (.clk(REF_CLK), .pad(PAD_CTRL), .drv(ext_drv),
    .val(ext_val), .pin(PIN_IN));

  initial forever #2.5 REF_CLK = ~REF_CLK;

  // ==========================================================
  // Helpers
  function automatic logic [31:0] rnd();
    seed = {seed[30:0], 1'b0} ^ (seed[31] ? 32'h04C1_1DB7 : 32'h0000_0000);
    return seed;
  endfunction
  task automatic summarize();
    $display("compared %0d mismatches %0d", n_compared, error_cnt);
    if (error_cnt == 0 && n_compared > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask
  task automatic chk(input string what, input logic [7:0] e,
                     input logic [7:0] g);
    n_compared++;
    if (g !== e) begin
      error_cnt++;
      $display("[FAIL] %s expected %h seen %h", what, e, g);
    end
  endtask
  // Request held until the edge that sees PREADY; one idle cycle follows
  task automatic apb(input logic w, input logic [11:0] a,
                     input logic [7:0] d);
    int n;
    @(posedge REF_CLK);
    PSEL <= 1;
    PENABLE <= 0;
    PWRITE <= w;
    PADDR <= a;
    PWDATA <= {24'h0000_00, d};
    @(posedge REF_CLK);
    PENABLE <= 1;
    n = 0;
    do begin
      @(posedge REF_CLK);
      n++;
    end while (PREADY !== 1'b1 && n < 50);
    if (n >= 50) chk("pready", 8'h01, 8'h00);
    q = PRDATA;
    err = PSLVERR;
    PSEL <= 0;
    PENABLE <= 0;
  endtask
  function automatic logic [11:0] za(int p, int k);
    return 12'(p * 8 + k * 4);
  endfunction
  function automatic logic [11:0] ha(int p, int k);
    return 12'h100 + 12'(p * 16 + k * 4);
  endfunction

  // ==========================================================
  // Pad and read expectations for every port
  task automatic check_all();
    logic [7:0] m, an, pe, ko, os, oe, ou, pu, rd, care;
    for (int p = 0; p < 7; p++) begin
      m = sgp_pkg::PIN_MASK[p];
      an = SHARE[p].analog & sgp_pkg::ANALOG_MASK[p];
      pe = SHARE[p].en & sgp_pkg::SHARE_MASK[p] & ~an;
      os = (p == sgp_pkg::G_IDX && OSC_EN) ? sgp_pkg::OSC_MASK_G : 8'h00;
      ko = (p == sgp_pkg::G_IDX) ? KBD_EN & sgp_pkg::KBD_MASK_G : 8'h00;
      oe = m & ~an & ~os & ((pe & SHARE[p].oe) | (~pe & ~ko & s_dir[p]));
      ou = ((pe & SHARE[p].dout) | (~pe & s_data[p])) & oe;
      pu = s_pull[p] & ~oe & ~an & ~os & m;
      chk("pad oe", oe, PAD_CTRL[p].oe & m);
      chk("pad out", ou, PAD_CTRL[p].out & oe);
      chk("pad pullup", pu, PAD_CTRL[p].pull_on & m);
      chk("pad slew", s_slew[p] & ~os & m, PAD_CTRL[p].slew & m);
      chk("pad drive", s_drv[p] & ~os & m, PAD_CTRL[p].drive & m);
      chk("pad analog", an, PAD_CTRL[p].analog & m);
      apb(0, za(p, 0), 8'h00);
      rd = ((s_dir[p] & s_data[p]) | (~s_dir[p] & PIN_IN[p])) & m & ~an & ~os;
      care = ext_drv[p] | oe | pu | s_dir[p] | an | os | ~m;
      chk("data read", rd & care, q[7:0] & care);
    end
  endtask

  // ==========================================================
  // Main sequence
  always @(posedge REF_CLK) begin
    cycles++;
    if (cycles == 20000) begin
      error_cnt++;
      summarize();
    end
  end

  initial begin
    s_slew = sgp_pkg::PIN_MASK;
    repeat (20) @(posedge REF_CLK);
    RST <= 0;
    repeat (2) @(posedge REF_CLK);
    for (int p = 0; p < 7; p++) begin
      chk("reset oe", 8'h00, PAD_CTRL[p].oe);
      chk("reset pad slew", sgp_pkg::PIN_MASK[p], PAD_CTRL[p].slew);
      chk("reset pad pullup", 8'h00, PAD_CTRL[p].pull_on);
      chk("reset pad analog", 8'h00, PAD_CTRL[p].analog);
      apb(0, za(p, 1), 8'h00);
      chk("reset dir", 8'h00, q[7:0]);
      apb(0, ha(p, 0), 8'h00);
      chk("reset pull", 8'h00, q[7:0]);
      apb(0, ha(p, 1), 8'h00);
      chk("reset slew", sgp_pkg::PIN_MASK[p], q[7:0]);
      total += $countones(q[7:0]);
      apb(0, ha(p, 2), 8'h00);
      chk("reset drive", 8'h00, q[7:0]);
    end
    chk("pin count", 8'd38, 8'(total));
    apb(0, 12'h0FC, 8'h00);
    chk("unmapped err", 8'h01, {7'h00, err});
    chk("unmapped data", 8'h00, q[7:0]);
    PSTRB <= 4'h0;
    apb(1, za(0, 1), 8'hFF);
    PSTRB <= 4'hF;
    apb(0, za(0, 1), 8'h00);
    chk("strobe off dir", 8'h00, q[7:0]);
    for (int it = 0; it < 40; it++) begin
      for (int p = 0; p < 7; p++) begin
        s_data[p] = 8'(rnd()) & sgp_pkg::PIN_MASK[p];
        s_dir[p] = 8'(rnd()) & sgp_pkg::PIN_MASK[p];
        s_pull[p] = 8'(rnd()) & sgp_pkg::PIN_MASK[p];
        s_slew[p] = 8'(rnd()) & sgp_pkg::PIN_MASK[p];
        s_drv[p] = 8'(rnd()) & sgp_pkg::PIN_MASK[p];
        apb(1, za(p, 0), s_data[p] | ~sgp_pkg::PIN_MASK[p]);
        apb(1, za(p, 1), s_dir[p]);
        apb(1, ha(p, 0), s_pull[p]);
        apb(1, ha(p, 1), s_slew[p]);
        apb(1, ha(p, 2), s_drv[p]);
      end
      @(posedge REF_CLK);
      // First two rounds plain ports, then one round where every SHARE claimant claims at once with random keyboard and oscillator enables, then random claims
      for (int p = 0; p < 7; p++) begin
        SHARE[p] <= (it < 2) ? '0 : (it == 2) ? '1 : rnd();
        ext_drv[p] <= 8'(rnd());
        ext_val[p] <= 8'(rnd());
      end
      KBD_EN <= (it < 2) ? 8'h00 : 8'(rnd());
      OSC_EN <= (it < 2) ? 1'b0 : 1'(rnd());
      repeat (4) @(posedge REF_CLK);
      check_all();
    end
    summarize();
  end
endmodule // sgp_top_test
